// ==== shared/guard_pkg.sv ====
// Notes on behaviour
// - selection limited to 0-3, 14-17; default 14
// - values 1,3,15,17 reset only when tripped
// - same gating for reset pin and comm
// - accepted reset while running cuts output
// - accepted reset clears thermal and brake duty
// - operator reset key only works when tripped
// - values 2,3,16,17: loss over 1 s trips
// - values 0,1,14,15: loss raises no fault
// - absent since power-on is no fault
// - jog loss without detection decelerates to stop
// - RS-485 on connector disables loss detection
// - values 14-17: stop key works every mode
// - values 0-3: no latch, stop only operator mode
// - latched stop released by stop-cancel from panel or unit
// - power-on or accepted reset pin clears latch
// - values 14-17: stop key in external decelerates, never coasts
// - values 14-17: stop from non-selected source latches stop
// - values 14-17: builtin stop during USB/RS-485 operator mode latches
// - selection writable when group is 0, kept on parameter clear
// - selection writable only when user group is 0
package guard_pkg;
	localparam int unsigned clock_mhz       = 250;
	localparam int unsigned loss_time_ms    = 1000;
	localparam int unsigned loss_cycles     = loss_time_ms * 1000 * clock_mhz;
	localparam logic [4:0]  sel_default     = 5'h0e;
	localparam logic [4:0]  sel_low_max     = 5'h03;
	localparam logic [4:0]  sel_high_min    = 5'h0e;
	localparam logic [4:0]  sel_high_max    = 5'h11;
	localparam logic [4:0]  sel_bit_fault   = 5'h01;
	localparam logic [4:0]  sel_bit_detect  = 5'h02;
	localparam logic [4:0]  sel_high_detect = 5'h10;
	localparam logic [3:0]  addr_selection  = 4'h0;
	localparam logic [3:0]  addr_control    = 4'h1;
	localparam logic [3:0]  addr_status     = 4'h2;
	localparam int unsigned ctl_group_bit   = 0;
	localparam int unsigned ctl_clear_bit   = 1;
	localparam logic [31:0] thermal_zero    = 32'h0000_0000;

	typedef enum logic [1:0] {
		mode_operator,
		mode_external,
		mode_network
	} op_mode_e;

	typedef enum logic [1:0] {
		src_panel,
		src_unit,
		src_usb,
		src_rs485
	} cmd_src_e;

	typedef struct packed {
		logic op_stop_key;
		logic op_reset_key;
		logic op_cancel;
		logic panel_stop_key;
		logic panel_cancel;
	} keys_s;

	typedef struct packed {
		logic output_disable;
		logic decel_stop;
		logic clear_thermal;
		logic clear_brake_duty;
	} drive_cmd_s;

	function automatic logic sel_legal(input logic [4:0] v);
		return (v <= sel_low_max) || ((v >= sel_high_min) && (v <= sel_high_max));
	endfunction
endpackage

// ==== hw/misoperation_guard.sv ====
`timescale 1ns/1ps
module misoperation_guard
	import guard_pkg::*;
#(
	parameter int unsigned loss_limit = loss_cycles
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// pins from outside
	input  wire logic        hardware_reset_input,
	input  wire logic        unit_present,
	input  wire logic        forward_start_input,
	input  wire logic        reverse_start_input,
	// drive state, same clock
	input  wire logic        comm_reset_req,
	input  wire logic        running,
	input  wire logic        tripped_other,
	input  wire logic        jog_active,
	input  wire logic        rs485_on_connector,
	input  wire op_mode_e    op_mode,
	input  wire cmd_src_e    operator_command_source_select,
	input  wire keys_s       keys,
	input  wire keys_s       key_from_unit,
	// outputs
	output logic             operator_loss_fault,
	output logic             latched_operator_stop,
	output logic             tripped,
	output drive_cmd_s       drive_cmd
);
	logic [2:0] rsync_ff;
	logic [1:0] psync_ff;
	logic [4:0] guard_selection_ff, nxt_guard_selection;
	logic       group_zero_ff, nxt_group_zero;
	logic       seen_ff, nxt_seen;
	logic [31:0] loss_cnt_ff, nxt_loss_cnt;
	logic       fault_ff, nxt_fault;
	logic       latch_ff, nxt_latch;
	logic       ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	drive_cmd_s cmd_ff, nxt_cmd;
	logic       pin_rise, present, reset_ok, reset_pin_acc, reset_any, detect, stop_hit, latch_hit;
	logic       bus_req;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsync_ff <= '0;
			psync_ff <= '0;
		end else begin
			rsync_ff <= {rsync_ff[1:0], hardware_reset_input};
			psync_ff <= {psync_ff[0], unit_present};
		end
	end
	assign pin_rise = rsync_ff[1] & ~rsync_ff[2];
	assign present  = psync_ff[1];

	assign tripped   = fault_ff | tripped_other;
	assign reset_ok  = ~(guard_selection_ff[0] & sel_bit_fault[0]) | tripped;
	assign reset_pin_acc = pin_rise & reset_ok;
	assign reset_any = (pin_rise | comm_reset_req) & reset_ok | (key_from_unit.op_reset_key & tripped);
	assign detect    = ((guard_selection_ff <= sel_low_max) ? ((guard_selection_ff & sel_bit_detect) != '0) :
		(guard_selection_ff >= sel_high_detect)) & ~rs485_on_connector;

	// stop key handling
	always_comb begin
		stop_hit  = 1'b0;
		latch_hit = 1'b0;
		if (guard_selection_ff >= sel_high_min) begin
			stop_hit  = keys.op_stop_key | keys.panel_stop_key;
			latch_hit = stop_hit & ((op_mode != mode_operator) ||
				(keys.panel_stop_key && operator_command_source_select != src_panel) ||
				(keys.op_stop_key && operator_command_source_select != src_unit));
		end else begin
			stop_hit = (keys.op_stop_key | keys.panel_stop_key) & (op_mode == mode_operator);
		end
	end

	always_comb begin
		nxt_seen     = seen_ff | present;
		nxt_loss_cnt = loss_cnt_ff;
		nxt_fault    = fault_ff;
		if (present || !seen_ff || !detect)
			nxt_loss_cnt = '0;
		else if (loss_cnt_ff < loss_limit)
			nxt_loss_cnt = loss_cnt_ff + 32'h1;
		if (reset_any)
			nxt_fault = 1'b0;
		if (detect && loss_cnt_ff >= loss_limit)
			nxt_fault = 1'b1;
		nxt_latch = latch_ff;
		if (key_from_unit.op_cancel || keys.panel_cancel || reset_pin_acc)
			nxt_latch = 1'b0;
		if (guard_selection_ff <= sel_low_max)
			nxt_latch = 1'b0;
		if (latch_hit)
			nxt_latch = 1'b1;
		nxt_cmd.output_disable   = reset_any & running;
		nxt_cmd.clear_thermal    = reset_any;
		nxt_cmd.clear_brake_duty = reset_any;
		nxt_cmd.decel_stop       = stop_hit | (jog_active & ~present & seen_ff & ~detect) |
			(latch_ff & (forward_start_input | reverse_start_input));
	end

	assign bus_req = read | write;
	always_comb begin
		nxt_guard_selection = guard_selection_ff;
		nxt_group_zero      = group_zero_ff;
		nxt_ack             = bus_req & ~ack_ff;
		nxt_rdata           = rdata_ff;
		if (bus_req && !ack_ff) begin
			if (write) begin
				unique case (address)
					addr_selection: if (group_zero_ff && sel_legal(writedata[4:0]))
						nxt_guard_selection = writedata[4:0];
					addr_control: begin
						nxt_group_zero = writedata[ctl_group_bit];
						if (writedata[ctl_clear_bit])
							nxt_guard_selection = guard_selection_ff;
					end
					default: nxt_group_zero = group_zero_ff;
				endcase
				nxt_rdata = thermal_zero;
			end else begin
				unique case (address)
					addr_selection: nxt_rdata = {27'h0, guard_selection_ff};
					addr_control:   nxt_rdata = {30'h0, 1'b0, group_zero_ff};
					addr_status:    nxt_rdata = {27'h0, present, tripped, latch_ff, fault_ff, seen_ff};
					default:        nxt_rdata = thermal_zero;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			guard_selection_ff <= sel_default;
			group_zero_ff      <= 1'b1;
			seen_ff            <= 1'b0;
			loss_cnt_ff        <= '0;
			fault_ff           <= 1'b0;
			latch_ff           <= 1'b0;
			ack_ff             <= 1'b0;
			rdata_ff           <= '0;
			cmd_ff             <= '0;
		end else begin
			guard_selection_ff <= nxt_guard_selection;
			group_zero_ff      <= nxt_group_zero;
			seen_ff            <= nxt_seen;
			loss_cnt_ff        <= nxt_loss_cnt;
			fault_ff           <= nxt_fault;
			latch_ff           <= nxt_latch;
			ack_ff             <= nxt_ack;
			rdata_ff           <= nxt_rdata;
			cmd_ff             <= nxt_cmd;
		end
	end

	assign waitrequest           = bus_req & ~ack_ff;
	assign readdata              = rdata_ff;
	assign operator_loss_fault   = fault_ff;
	assign latched_operator_stop = latch_ff;
	assign drive_cmd             = cmd_ff;

	property p_sel_legal;
		@(posedge clock) disable iff (rst) sel_legal(guard_selection_ff);
	endproperty
	a_sel_legal: assert property (p_sel_legal) else $error("selection illegal");

	property p_gated_reset;
		@(posedge clock) disable iff (rst)
			(comm_reset_req && guard_selection_ff[0] && !tripped && !pin_rise && !key_from_unit.op_reset_key)
			|=> !drive_cmd.clear_thermal;
	endproperty
	a_gated_reset: assert property (p_gated_reset) else $error("reset accepted outside trip");

	property p_coast;
		@(posedge clock) disable iff (rst) (reset_any && running) |=> drive_cmd.output_disable;
	endproperty
	a_coast: assert property (p_coast) else $error("no output cut on reset");

	property p_clear;
		@(posedge clock) disable iff (rst) reset_any |=> (drive_cmd.clear_thermal && drive_cmd.clear_brake_duty);
	endproperty
	a_clear: assert property (p_clear) else $error("accumulators not cleared");

	property p_no_fault;
		@(posedge clock) disable iff (rst) !detect |=> !$rose(operator_loss_fault);
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("loss fault while detection off");

	property p_trip;
		@(posedge clock) disable iff (rst) (detect && loss_cnt_ff >= loss_limit) |=> operator_loss_fault;
	endproperty
	a_trip: assert property (p_trip) else $error("loss did not trip");

	property p_timer;
		@(posedge clock) disable iff (rst) present |=> loss_cnt_ff == '0;
	endproperty
	a_timer: assert property (p_timer) else $error("timer not restarted");

	property p_no_latch_low;
		@(posedge clock) disable iff (rst) (guard_selection_ff <= sel_low_max) |=> !latched_operator_stop;
	endproperty
	a_no_latch_low: assert property (p_no_latch_low) else $error("latch in low selections");

	property p_latch_set;
		@(posedge clock) disable iff (rst) latch_hit |=> latched_operator_stop;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("stop not latched");

	property p_pin_gate;
		@(posedge clock) disable iff (rst) (pin_rise && guard_selection_ff[0] && !tripped && !comm_reset_req &&
			!key_from_unit.op_reset_key) |=> !drive_cmd.clear_thermal;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin reset accepted outside trip");

	property p_pin_accept;
		@(posedge clock) disable iff (rst) reset_pin_acc |=> drive_cmd.clear_brake_duty;
	endproperty
	a_pin_accept: assert property (p_pin_accept) else $error("pin reset not applied");

	property p_key_gate;
		@(posedge clock) disable iff (rst) (key_from_unit.op_reset_key && !tripped && !pin_rise && !comm_reset_req)
			|=> !drive_cmd.clear_thermal;
	endproperty
	a_key_gate: assert property (p_key_gate) else $error("reset key accepted outside trip");

	property p_key_accept;
		@(posedge clock) disable iff (rst) (key_from_unit.op_reset_key && tripped) |=> drive_cmd.clear_thermal;
	endproperty
	a_key_accept: assert property (p_key_accept) else $error("reset key ignored in trip");

	property p_open_reset;
		@(posedge clock) disable iff (rst) (comm_reset_req && !guard_selection_ff[0]) |=> drive_cmd.clear_thermal;
	endproperty
	a_open_reset: assert property (p_open_reset) else $error("reset refused while open");

	property p_no_coast_idle;
		@(posedge clock) disable iff (rst) (reset_any && !running) |=> !drive_cmd.output_disable;
	endproperty
	a_no_coast_idle: assert property (p_no_coast_idle) else $error("output cut while stopped");

	property p_no_clear;
		@(posedge clock) disable iff (rst) !reset_any |=> !drive_cmd.clear_thermal;
	endproperty
	a_no_clear: assert property (p_no_clear) else $error("accumulators cleared without reset");

	property p_absent_start;
		@(posedge clock) disable iff (rst) !seen_ff |=> !operator_loss_fault;
	endproperty
	a_absent_start: assert property (p_absent_start) else $error("fault before unit seen");

	property p_seen_sticky;
		@(posedge clock) disable iff (rst) seen_ff |=> seen_ff;
	endproperty
	a_seen_sticky: assert property (p_seen_sticky) else $error("seen flag lost");

	property p_rs485;
		@(posedge clock) disable iff (rst) rs485_on_connector |-> !detect;
	endproperty
	a_rs485: assert property (p_rs485) else $error("detection on with connector link");

	property p_detect_high;
		@(posedge clock) disable iff (rst) (guard_selection_ff >= sel_high_detect && !rs485_on_connector) |-> detect;
	endproperty
	a_detect_high: assert property (p_detect_high) else $error("detection off in trip selection");

	property p_detect_off;
		@(posedge clock) disable iff (rst) (guard_selection_ff == sel_high_min) |-> !detect;
	endproperty
	a_detect_off: assert property (p_detect_off) else $error("detection on in default selection");

	property p_count_up;
		@(posedge clock) disable iff (rst) (detect && seen_ff && !present && loss_cnt_ff < loss_limit)
			|=> loss_cnt_ff == $past(loss_cnt_ff) + 32'h1;
	endproperty
	a_count_up: assert property (p_count_up) else $error("loss timer not counting");

	property p_count_cap;
		@(posedge clock) disable iff (rst) loss_cnt_ff <= loss_limit;
	endproperty
	a_count_cap: assert property (p_count_cap) else $error("loss timer past limit");

	property p_fault_hold;
		@(posedge clock) disable iff (rst) (operator_loss_fault && !reset_any) |=> operator_loss_fault;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("loss fault dropped");

	property p_fault_clear;
		@(posedge clock) disable iff (rst) (reset_any && !(detect && loss_cnt_ff >= loss_limit))
			|=> !operator_loss_fault;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("loss fault kept after reset");

	property p_trip_out;
		@(posedge clock) disable iff (rst) operator_loss_fault |-> tripped;
	endproperty
	a_trip_out: assert property (p_trip_out) else $error("loss fault not tripping");

	property p_jog_decel;
		@(posedge clock) disable iff (rst) (jog_active && !present && seen_ff && !detect) |=> drive_cmd.decel_stop;
	endproperty
	a_jog_decel: assert property (p_jog_decel) else $error("jog loss without stop");

	property p_stop_high;
		@(posedge clock) disable iff (rst) (guard_selection_ff >= sel_high_min && keys.op_stop_key)
			|=> drive_cmd.decel_stop;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop key ignored");

	property p_ext_latch;
		@(posedge clock) disable iff (rst) (guard_selection_ff >= sel_high_min && keys.panel_stop_key &&
			op_mode == mode_external) |=> (latched_operator_stop && drive_cmd.decel_stop);
	endproperty
	a_ext_latch: assert property (p_ext_latch) else $error("external stop not decelerated");

	property p_stop_low;
		@(posedge clock) disable iff (rst) (guard_selection_ff <= sel_low_max && op_mode != mode_operator &&
			!jog_active && !latched_operator_stop) |=> !drive_cmd.decel_stop;
	endproperty
	a_stop_low: assert property (p_stop_low) else $error("stop outside operator mode");

	property p_cancel;
		@(posedge clock) disable iff (rst) (key_from_unit.op_cancel && !latch_hit) |=> !latched_operator_stop;
	endproperty
	a_cancel: assert property (p_cancel) else $error("unit cancel ignored");

	property p_panel_cancel;
		@(posedge clock) disable iff (rst) (keys.panel_cancel && !latch_hit) |=> !latched_operator_stop;
	endproperty
	a_panel_cancel: assert property (p_panel_cancel) else $error("panel cancel ignored");

	property p_pin_clear;
		@(posedge clock) disable iff (rst) (reset_pin_acc && !latch_hit) |=> !latched_operator_stop;
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("pin reset kept latch");

	property p_latch_hold;
		@(posedge clock) disable iff (rst) (latched_operator_stop && !key_from_unit.op_cancel && !keys.panel_cancel &&
			!reset_pin_acc && guard_selection_ff >= sel_high_min) |=> latched_operator_stop;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch released without cancel");

	property p_restart_block;
		@(posedge clock) disable iff (rst) (latched_operator_stop && forward_start_input) |=> drive_cmd.decel_stop;
	endproperty
	a_restart_block: assert property (p_restart_block) else $error("restart while latched");

	property p_usb_panel;
		@(posedge clock) disable iff (rst) (guard_selection_ff >= sel_high_min && op_mode == mode_operator &&
			keys.panel_stop_key && operator_command_source_select inside {src_usb, src_rs485})
			|=> latched_operator_stop;
	endproperty
	a_usb_panel: assert property (p_usb_panel) else $error("panel stop not latched");

	property p_selected_src;
		@(posedge clock) disable iff (rst) (guard_selection_ff >= sel_high_min && op_mode == mode_operator &&
			keys.panel_stop_key && !keys.op_stop_key && operator_command_source_select == src_panel &&
			!latched_operator_stop) |=> !latched_operator_stop;
	endproperty
	a_selected_src: assert property (p_selected_src) else $error("selected source latched");

	property p_group_block;
		@(posedge clock) disable iff (rst) (write && !ack_ff && address == addr_selection && !group_zero_ff)
			|=> $stable(guard_selection_ff);
	endproperty
	a_group_block: assert property (p_group_block) else $error("selection written while locked");

	property p_illegal_block;
		@(posedge clock) disable iff (rst) (write && !ack_ff && address == addr_selection &&
			!sel_legal(writedata[4:0])) |=> $stable(guard_selection_ff);
	endproperty
	a_illegal_block: assert property (p_illegal_block) else $error("illegal selection taken");

	property p_clear_keep;
		@(posedge clock) disable iff (rst) (write && !ack_ff && address == addr_control)
			|=> $stable(guard_selection_ff);
	endproperty
	a_clear_keep: assert property (p_clear_keep) else $error("selection changed by clear");
endmodule

// ==== dv/op_unit_model.sv ====
`timescale 1ns/1ps
module op_unit_model
	import guard_pkg::*;
(
	// clock
	input  wire logic clock,
	// towards the guard
	output logic      unit_present,
	output keys_s     keys,
	output keys_s     key_from_unit
);
	// absent before power-on
	initial begin
		unit_present  = 1'b0;
		keys          = '0;
		key_from_unit = '0;
	end
	task automatic plug(input logic on);
		@(posedge clock);
		unit_present <= on;
	endtask
	// one-cycle key pulse
	task automatic press(input keys_s k);
		@(posedge clock);
		keys          <= k;
		key_from_unit <= k;
		@(posedge clock);
		keys          <= '0;
		key_from_unit <= '0;
	endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import guard_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        hw = 1'b0;
	logic        comm = 1'b0;
	logic        jog = 1'b0;
	logic        rs485 = 1'b0;
	logic        clr = 1'b0;
	logic        fwd = 1'b0;
	logic        rev = 1'b0;
	logic        run = 1'b1;
	logic        toth = 1'b0;
	cmd_src_e    src = src_panel;
	logic        present, loss, latch, trip;
	op_mode_e    mode = mode_external;
	keys_s       keys, ukeys;
	drive_cmd_s  cmd;
	drive_cmd_s  seen = '0;
	int          n_errors = 0;
	int          tests_run = 0;

	always #2 clock = ~clock;
	always @(posedge clock) seen <= clr ? '0 : (seen | cmd);

	// reverse start input stays released, forward driven only in t_stop
	misoperation_guard #(.loss_limit(20)) misoperation_guard_i (
		.clock(clock), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .hardware_reset_input(hw), .unit_present(present),
		.forward_start_input(fwd), .reverse_start_input(rev), .comm_reset_req(comm), .running(run),
		.tripped_other(toth), .jog_active(jog), .rs485_on_connector(rs485), .op_mode(mode),
		.operator_command_source_select(src), .keys(keys), .key_from_unit(ukeys),
		.operator_loss_fault(loss), .latched_operator_stop(latch), .tripped(trip), .drive_cmd(cmd));
	op_unit_model op_unit_model_i (.clock(clock), .unit_present(present), .keys(keys), .key_from_unit(ukeys));

	task automatic give_verdict;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		logic w;
		@(posedge clock);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= ~wr;
		do begin
			@(negedge clock);
			w = waitrequest;
			q = readdata;
			@(posedge clock);
		end while (w !== 1'b0);
		write <= 1'b0;
		read  <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk("readdata", q, e);
	endtask
	task automatic arm;
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
	endtask
	task automatic req(input logic pin);
		arm;
		if (pin) hw <= 1'b1;
		else comm <= 1'b1;
		@(posedge clock);
		comm <= 1'b0;
		repeat (3) @(posedge clock);
		hw <= 1'b0;
		settle(6);
	endtask
	task automatic key(input keys_s k);
		arm;
		op_unit_model_i.press(k);
		settle(4);
	endtask
	task automatic set_mode(input op_mode_e m);
		@(posedge clock);
		mode <= m;
	endtask

	task automatic t_regs;
		rd(addr_selection, 32'h0e);
		wr(addr_selection, 32'h04);
		rd(addr_selection, 32'h0e);
		wr(addr_control, 32'h0);
		wr(addr_selection, 32'h11);
		rd(addr_selection, 32'h0e);
		wr(addr_control, 32'h3);
		wr(addr_selection, 32'h11);
		wr(addr_control, 32'h3);
		rd(addr_selection, 32'h11);
		rd(4'hf, 32'h0);
	endtask
	task automatic t_loss;
		settle(40);
		chk("loss_fault", loss, 1'b0);
		op_unit_model_i.plug(1'b1);
		settle(10);
		op_unit_model_i.plug(1'b0);
		settle(10);
		op_unit_model_i.plug(1'b1);
		settle(10);
		op_unit_model_i.plug(1'b0);
		settle(10);
		chk("loss_fault", loss, 1'b0);
		settle(30);
		chk("loss_fault", loss, 1'b1);
		chk("tripped", trip, 1'b1);
		op_unit_model_i.plug(1'b1);
		settle(5);
		req(1'b0);
		chk("loss_fault", loss, 1'b0);
		chk("output_disable", seen.output_disable, 1'b1);
		@(posedge clock);
		rs485 <= 1'b1;
		op_unit_model_i.plug(1'b0);
		settle(40);
		chk("loss_fault", loss, 1'b0);
		wr(addr_selection, 32'h0e);
		rs485 <= 1'b0;
		jog   <= 1'b1;
		set_mode(mode_operator);
		settle(40);
		chk("loss_fault", loss, 1'b0);
		chk("decel_stop", seen.decel_stop, 1'b1);
		op_unit_model_i.plug(1'b1);
		jog <= 1'b0;
		set_mode(mode_external);
	endtask
	task automatic t_reset;
		wr(addr_selection, 32'h0f);
		req(1'b0);
		chk("output_disable", seen.output_disable, 1'b0);
		req(1'b1);
		chk("output_disable", seen.output_disable, 1'b0);
		wr(addr_selection, 32'h0e);
		key(keys_s'(5'h08));
		chk("output_disable", seen.output_disable, 1'b0);
		req(1'b0);
		chk("clear_thermal", seen.clear_thermal, 1'b1);
		chk("clear_brake_duty", seen.clear_brake_duty, 1'b1);
	endtask
	task automatic t_stop;
		key(keys_s'(5'h10));
		chk("latch", latch, 1'b1);
		chk("decel_stop", seen.decel_stop, 1'b1);
		key(keys_s'(5'h04));
		chk("latch", latch, 1'b0);
		key(keys_s'(5'h10));
		req(1'b1);
		chk("latch", latch, 1'b0);
		set_mode(mode_operator);
		key(keys_s'(5'h10));
		chk("latch", latch, 1'b1);
		arm;
		fwd <= 1'b1;
		settle(4);
		chk("decel_stop", seen.decel_stop, 1'b1);
		@(posedge clock);
		fwd <= 1'b0;
		key(keys_s'(5'h04));
		wr(addr_selection, 32'h00);
		key(keys_s'(5'h02));
		chk("decel_stop", seen.decel_stop, 1'b1);
		set_mode(mode_external);
		key(keys_s'(5'h10));
		chk("latch", latch, 1'b0);
		chk("decel_stop", seen.decel_stop, 1'b0);
		rd(addr_status, 32'h11);
	endtask

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_loss;
		t_reset;
		t_stop;
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		give_verdict;
	end
endmodule
